/* File: rtl/wcm_pkg.sv */
// Package with the register map, field layout and reset values of the window comparator.
// Behaviour
// R1: Each top-byte limit, high and low, is compared with result bits 11:4.
// R2: High-limit low nibble sits in band register bits 7:4, resets to all ones.
// R3: Low-limit low nibble sits in count register bits 7:4, resets to zero.
// R4: One 4-bit band value in bits 3:0 serves both limits of a channel.
// R5: Band value is shifted left three places, forming a 7-bit offset on the limit.
// R6: Event flag sets only after n+1 consecutive exceeding samples, n from bits 3:0.
// R7: Exceeding means above high or below low, with the band applied before return.
package wcm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int RES_W = 12;
   localparam int CH_W = 3;
   localparam int NUM_CH = 2;
   localparam logic [CH_W-1:0] FIRST_CH = 3'h6;
   localparam logic [ADDR_W-1:0] CH6_UPPER_NIBBLE_AND_BAND = 8'h38;
   localparam logic [ADDR_W-1:0] CH6_UPPER_LIMIT_MSB = 8'h39;
   localparam logic [ADDR_W-1:0] CH6_LOWER_NIBBLE_AND_COUNT = 8'h3A;
   localparam logic [ADDR_W-1:0] CH6_LOWER_LIMIT_MSB = 8'h3B;
   localparam logic [ADDR_W-1:0] CH7_UPPER_NIBBLE_AND_BAND = 8'h3C;
   localparam logic [ADDR_W-1:0] CH7_UPPER_LIMIT_MSB = 8'h3D;
   localparam logic [ADDR_W-1:0] CH7_LOWER_NIBBLE_AND_COUNT = 8'h3E;
   localparam logic [ADDR_W-1:0] CH7_LOWER_LIMIT_MSB = 8'h3F;
   localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h04;
   localparam logic [DATA_W-1:0] BAND_RESET = 8'hF0;
   localparam logic [DATA_W-1:0] UPPER_MSB_RESET = 8'hFF;
   localparam logic [DATA_W-1:0] COUNT_RESET = 8'h00;
   localparam logic [DATA_W-1:0] LOWER_MSB_RESET = 8'h00;
   localparam int NIB_HI = 7;
   localparam int NIB_LO = 4;
   localparam int FIELD_HI = 3;
   localparam int BAND_SHIFT = 3;
   localparam logic [1:0] SEL_BAND = 2'h0;
   localparam logic [1:0] SEL_UPPER = 2'h1;
   localparam logic [1:0] SEL_COUNT = 2'h2;
   localparam logic [1:0] SEL_LOWER = 2'h3;
endpackage

/* File: rtl/wcm_window_comparator.sv */
// Digital window comparator for analog channels 6 and 7 with its byte registers.
module wcm_window_comparator (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [wcm_pkg::ADDR_W-1:0] regAddr,
   input wire logic [wcm_pkg::DATA_W-1:0] regWrData,
   output logic [wcm_pkg::DATA_W-1:0] regRdData,
   input wire logic sampleValid,
   input wire logic [wcm_pkg::CH_W-1:0] sampleChannel,
   input wire logic [wcm_pkg::RES_W-1:0] sampleResult,
   input wire logic [wcm_pkg::NUM_CH-1:0] eventClear,
   output logic [wcm_pkg::NUM_CH-1:0] eventFlag
);
   logic [wcm_pkg::DATA_W-1:0] bandReg_q [wcm_pkg::NUM_CH];
   logic [wcm_pkg::DATA_W-1:0] upperMsb_q [wcm_pkg::NUM_CH];
   logic [wcm_pkg::DATA_W-1:0] countReg_q [wcm_pkg::NUM_CH];
   logic [wcm_pkg::DATA_W-1:0] lowerMsb_q [wcm_pkg::NUM_CH];
   logic [wcm_pkg::NUM_CH-1:0] highActive_q;
   logic [wcm_pkg::NUM_CH-1:0] lowActive_q;
   logic [4:0] runCount_q [wcm_pkg::NUM_CH];
   logic [wcm_pkg::NUM_CH-1:0] eventFlag_q;
   logic [wcm_pkg::DATA_W-1:0] regRdData_q;
   logic [wcm_pkg::NUM_CH-1:0] chHit;
   logic [wcm_pkg::NUM_CH-1:0] overHigh;
   logic [wcm_pkg::NUM_CH-1:0] underLow;
   logic [wcm_pkg::NUM_CH-1:0] exceed;
   logic [wcm_pkg::RES_W-1:0] upperLimit [wcm_pkg::NUM_CH];
   logic [wcm_pkg::RES_W-1:0] lowerLimit [wcm_pkg::NUM_CH];
   logic [wcm_pkg::RES_W-1:0] bandOffset [wcm_pkg::NUM_CH];
   logic [wcm_pkg::RES_W-1:0] upperReturn [wcm_pkg::NUM_CH];
   logic [wcm_pkg::RES_W-1:0] lowerReturn [wcm_pkg::NUM_CH];

   // Decodes a byte address into channel index, register select and a hit flag.
   function automatic logic [3:0] decodeAddr(input logic [wcm_pkg::ADDR_W-1:0] addr);
      logic [wcm_pkg::ADDR_W-1:0] rel;
      logic hit;
      rel = addr - wcm_pkg::CH6_UPPER_NIBBLE_AND_BAND;
      hit = (addr >= wcm_pkg::CH6_UPPER_NIBBLE_AND_BAND) &&
            (addr <= wcm_pkg::CH7_LOWER_LIMIT_MSB);
      decodeAddr = {hit, rel[2], rel[1:0]};
   endfunction

   logic [3:0] wrDec;
   logic [3:0] rdDec;
   assign wrDec = decodeAddr(regAddr);
   assign rdDec = decodeAddr(regAddr);

   always_comb begin
      for (int i = 0; i < wcm_pkg::NUM_CH; i++) begin
         chHit[i] = sampleValid &&
                    (sampleChannel == wcm_pkg::FIRST_CH + wcm_pkg::CH_W'(i));
         // Full 12-bit limits: top byte against bits 11:4, nibble against bits 3:0.
         upperLimit[i] = {upperMsb_q[i],
                          bandReg_q[i][wcm_pkg::NIB_HI:wcm_pkg::NIB_LO]}; // see R1 R2
         lowerLimit[i] = {lowerMsb_q[i],
                          countReg_q[i][wcm_pkg::NIB_HI:wcm_pkg::NIB_LO]}; // see R1 R3
         bandOffset[i] = {5'h00, bandReg_q[i][wcm_pkg::FIELD_HI:0], 3'h0}; // see R4 R5
         // Saturate so a wide band never wraps the return level past the range ends.
         upperReturn[i] = (upperLimit[i] >= bandOffset[i]) ?
                          upperLimit[i] - bandOffset[i] : 12'h000; // see R5
         lowerReturn[i] = ({1'b0, lowerLimit[i]} + {1'b0, bandOffset[i]} > 13'h0FFF) ?
                          12'hFFF : lowerLimit[i] + bandOffset[i]; // see R5
         overHigh[i] = highActive_q[i] ? (sampleResult > upperReturn[i]) :
                       (sampleResult > upperLimit[i]); // see R7
         underLow[i] = lowActive_q[i] ? (sampleResult < lowerReturn[i]) :
                       (sampleResult < lowerLimit[i]); // see R7
         exceed[i] = overHigh[i] || underLow[i];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < wcm_pkg::NUM_CH; i++) begin
            bandReg_q[i] <= wcm_pkg::BAND_RESET; // see R2
            upperMsb_q[i] <= wcm_pkg::UPPER_MSB_RESET;
            countReg_q[i] <= wcm_pkg::COUNT_RESET; // see R3
            lowerMsb_q[i] <= wcm_pkg::LOWER_MSB_RESET;
         end
      end else if (regWrEn && wrDec[3]) begin
         unique case (wrDec[1:0])
            wcm_pkg::SEL_BAND: bandReg_q[wrDec[2]] <= regWrData;
            wcm_pkg::SEL_UPPER: upperMsb_q[wrDec[2]] <= regWrData;
            wcm_pkg::SEL_COUNT: countReg_q[wrDec[2]] <= regWrData;
            wcm_pkg::SEL_LOWER: lowerMsb_q[wrDec[2]] <= regWrData;
         endcase
      end
   end

   // Reads return one cycle later; unmapped addresses read as zero.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         regRdData_q <= 8'h00;
      end else if (regRdEn) begin
         if (!rdDec[3]) begin
            regRdData_q <= 8'h00;
         end else begin
            unique case (rdDec[1:0])
               wcm_pkg::SEL_BAND: regRdData_q <= bandReg_q[rdDec[2]];
               wcm_pkg::SEL_UPPER: regRdData_q <= upperMsb_q[rdDec[2]];
               wcm_pkg::SEL_COUNT: regRdData_q <= countReg_q[rdDec[2]];
               wcm_pkg::SEL_LOWER: regRdData_q <= lowerMsb_q[rdDec[2]];
            endcase
         end
      end
   end

   // Band state: once a limit is crossed, the return level is moved by the offset.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         highActive_q <= '0;
         lowActive_q <= '0;
      end else begin
         for (int i = 0; i < wcm_pkg::NUM_CH; i++) begin
            if (chHit[i]) begin
               highActive_q[i] <= overHigh[i]; // see R7
               lowActive_q[i] <= underLow[i]; // see R7
            end
         end
      end
   end

   // The run counter saturates at 16 so a long excursion cannot wrap and re-arm.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < wcm_pkg::NUM_CH; i++) begin
            runCount_q[i] <= 5'h00;
         end
      end else begin
         for (int i = 0; i < wcm_pkg::NUM_CH; i++) begin
            if (chHit[i]) begin
               if (!exceed[i]) begin
                  runCount_q[i] <= 5'h00; // see R6
               end else if (runCount_q[i] != 5'h10) begin
                  runCount_q[i] <= runCount_q[i] + 5'h01; // see R6
               end
            end
         end
      end
   end

   // A new event in the same cycle as a clear keeps the flag set.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         eventFlag_q <= '0;
      end else begin
         for (int i = 0; i < wcm_pkg::NUM_CH; i++) begin
            if (chHit[i] && exceed[i] &&
                runCount_q[i] == {1'b0, countReg_q[i][wcm_pkg::FIELD_HI:0]}) begin
               eventFlag_q[i] <= 1'b1; // see R6
            end else if (eventClear[i]) begin
               eventFlag_q[i] <= 1'b0;
            end
         end
      end
   end

   assign regRdData = regRdData_q;
   assign eventFlag = eventFlag_q;

   property p_top_byte_high;
      @(posedge ref_clk) disable iff (!rst_n)
      chHit[0] && sampleResult[11:4] > upperMsb_q[0] |-> overHigh[0];
   endproperty
   a_top_byte_high: assert property (p_top_byte_high) else $error("high byte compare missed"); // see R1

   property p_top_byte_low;
      @(posedge ref_clk) disable iff (!rst_n)
      chHit[1] && sampleResult[11:4] < lowerMsb_q[1] |-> underLow[1];
   endproperty
   a_top_byte_low: assert property (p_top_byte_low) else $error("low byte compare missed"); // see R1

   // With equal top bytes the nibble alone decides a fresh high crossing.
   property p_nibble_high;
      @(posedge ref_clk) disable iff (!rst_n)
      chHit[1] && !highActive_q[1] && sampleResult[11:4] == upperMsb_q[1] &&
      sampleResult[3:0] > bandReg_q[1][7:4] |-> overHigh[1];
   endproperty
   a_nibble_high: assert property (p_nibble_high) else $error("high nibble compare missed"); // see R2

   property p_band_reset;
      @(posedge ref_clk) !rst_n |=>
      bandReg_q[0] == wcm_pkg::BAND_RESET && bandReg_q[1] == wcm_pkg::BAND_RESET;
   endproperty
   a_band_reset: assert property (p_band_reset) else $error("band register reset wrong"); // see R2

   property p_count_reset;
      @(posedge ref_clk) !rst_n |=> countReg_q[0] == wcm_pkg::COUNT_RESET && eventFlag == 2'b00;
   endproperty
   a_count_reset: assert property (p_count_reset) else $error("count register reset wrong"); // see R3

   property p_high_return;
      @(posedge ref_clk) disable iff (!rst_n)
      chHit[1] && highActive_q[1] && sampleResult != 12'h000 &&
      {1'b0, sampleResult} + {6'h00, bandReg_q[1][3:0], 3'h0} > {1'b0, upperLimit[1]} |->
      overHigh[1];
   endproperty
   a_high_return: assert property (p_high_return) else $error("high band not applied"); // see R4

   property p_low_return;
      @(posedge ref_clk) disable iff (!rst_n)
      chHit[1] && lowActive_q[1] && sampleResult != 12'hFFF &&
      {1'b0, sampleResult} < {1'b0, lowerLimit[1]} + {6'h00, bandReg_q[1][3:0], 3'h0} |->
      underLow[1];
   endproperty
   a_low_return: assert property (p_low_return) else $error("low band offset wrong"); // see R5

   sequence s_final_sample;
      chHit[0] && exceed[0] && runCount_q[0] == {1'b0, countReg_q[0][3:0]};
   endsequence
   property p_event_set;
      @(posedge ref_clk) disable iff (!rst_n)
      s_final_sample |=> eventFlag[0];
   endproperty
   a_event_set: assert property (p_event_set) else $error("event flag not set after run"); // see R6

   property p_event_cause;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(eventFlag[1]) |-> $past(chHit[1]) && $past(exceed[1]) &&
      $past(runCount_q[1]) == {1'b0, $past(countReg_q[1][3:0])};
   endproperty
   a_event_cause: assert property (p_event_cause) else $error("event flag set early"); // see R6

   property p_run_clear;
      @(posedge ref_clk) disable iff (!rst_n)
      chHit[0] && !exceed[0] |=> runCount_q[0] == 5'h00;
   endproperty
   a_run_clear: assert property (p_run_clear) else $error("run count not cleared"); // see R6
endmodule

/* File: test/wcm_window_comparator_tb_top.sv */
// Self-checking testbench for the channel 6 and 7 window comparator.
module wcm_window_comparator_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic refClk, rstN, wrEn, rdEn, smpValid;
   logic [7:0] addr, wrData, rdData;
   logic [2:0] smpCh;
   logic [11:0] smpRes;
   logic [1:0] evClr, evFlag;
   int errorCnt = 0;
   int numChecks = 0;

   wcm_window_comparator i_wcm_window_comparator (.ref_clk(refClk), .rst_n(rstN),
      .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr), .regWrData(wrData), .regRdData(rdData),
      .sampleValid(smpValid), .sampleChannel(smpCh), .sampleResult(smpRes),
      .eventClear(evClr), .eventFlag(evFlag));

   initial begin
      refClk = 1'b0;
      forever #5 refClk = ~refClk;
   end

   task automatic finish_test;
      if (errorCnt == 0 && numChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic [1:0] got, input logic [1:0] exp);
      numChecks++;
      if (got !== exp) begin
         errorCnt++;
         $display("[ERR] %0t flags %b expected %b", $time, got, exp);
      end
   endtask

   // Every operation ends with an idle cycle so no strobe is set twice in one step.
   task automatic cyc;
      @(posedge refClk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wrEn = 1'b1;
      addr = a;
      wrData = d;
      cyc();
      wrEn = 1'b0;
      cyc();
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      rdEn = 1'b1;
      addr = a;
      cyc();
      rdEn = 1'b0;
      chk_reg(rdData, exp);
      cyc();
   endtask

   task automatic smp(input logic [2:0] ch, input logic [11:0] r, input logic [1:0] exp);
      smpValid = 1'b1;
      smpCh = ch;
      smpRes = r;
      cyc();
      smpValid = 1'b0;
      cyc();
      chk_flag(evFlag, exp);
   endtask

   task automatic clr;
      evClr = 2'h3;
      cyc();
      evClr = 2'h0;
      cyc();
      chk_flag(evFlag, 2'h0);
   endtask

   task automatic t_reset;
      logic [7:0] rv [8] = '{8'hF0, 8'hFF, 8'h00, 8'h00, 8'hF0, 8'hFF, 8'h00, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rd(8'h38 + 8'(i), rv[i]);
      end
      rd(8'h40, 8'h00);
   endtask

   task automatic t_rw;
      for (int i = 0; i < 8; i++) begin
         wr(8'h38 + 8'(i), 8'h5A ^ 8'(i * 37));
      end
      wr(8'h37, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         rd(8'h38 + 8'(i), 8'h5A ^ 8'(i * 37));
      end
      rd(8'h37, 8'h00);
   endtask

   task automatic t_nib_low;
      wr(8'h39, 8'h80);
      wr(8'h38, 8'h50);
      wr(8'h3A, 8'h00);
      wr(8'h3B, 8'h00);
      smp(3'h6, 12'h805, 2'h0);
      smp(3'h6, 12'h806, 2'h1);
      clr();
      wr(8'h3B, 8'h10);
      wr(8'h3A, 8'h30);
      smp(3'h6, 12'h103, 2'h0);
      smp(3'h6, 12'h102, 2'h1);
      clr();
      smp(3'h6, 12'h104, 2'h0);
      smp(3'h6, 12'h900, 2'h1);
      clr();
   endtask

   task automatic t_count;
      wr(8'h3D, 8'h80);
      wr(8'h3C, 8'h00);
      wr(8'h3E, 8'h02);
      wr(8'h3F, 8'h00);
      smp(3'h7, 12'h810, 2'h0);
      smp(3'h7, 12'h810, 2'h0);
      smp(3'h5, 12'hFFF, 2'h0);
      smp(3'h7, 12'h810, 2'h2);
      smp(3'h7, 12'h100, 2'h2);
      clr();
      smp(3'h7, 12'h810, 2'h0);
      smp(3'h7, 12'h810, 2'h0);
      smp(3'h7, 12'h7FF, 2'h0);
      smp(3'h7, 12'h810, 2'h0);
      smp(3'h7, 12'h810, 2'h0);
      smp(3'h7, 12'h810, 2'h2);
      clr();
   endtask

   // A band of 2 gives a 16-code offset on both limits of channel 7. The flag rises only on
   // the exact second sample of a run, so a flag on the in-band sample shows it still counts.
   task automatic t_band;
      wr(8'h3C, 8'h02);
      wr(8'h3E, 8'h01);
      wr(8'h3F, 8'h20);
      smp(3'h7, 12'h400, 2'h0);
      smp(3'h7, 12'h801, 2'h0);
      smp(3'h7, 12'h7F8, 2'h2);
      clr();
      smp(3'h7, 12'h7EF, 2'h0);
      smp(3'h7, 12'h7F8, 2'h0);
      smp(3'h7, 12'h1FF, 2'h0);
      smp(3'h7, 12'h20F, 2'h2);
      clr();
      smp(3'h7, 12'h211, 2'h0);
      smp(3'h7, 12'h20F, 2'h0);
   endtask

   // A reset in mid-run must drop a set flag and restore every register.
   task automatic t_mid_reset;
      smp(3'h7, 12'hFFF, 2'h0);
      smp(3'h7, 12'hFFF, 2'h2);
      rstN = 1'b0;
      cyc();
      cyc();
      rstN = 1'b1;
      chk_flag(evFlag, 2'h0);
      t_reset();
   endtask

   initial begin
      rstN = 1'b0;
      wrEn = 1'b0;
      rdEn = 1'b0;
      addr = 8'h00;
      wrData = 8'h00;
      smpValid = 1'b0;
      smpCh = 3'h0;
      smpRes = 12'h000;
      evClr = 2'h0;
      repeat (12) @(posedge refClk);
      #1;
      rstN = 1'b1;
      t_reset();
      t_rw();
      t_nib_low();
      t_count();
      t_band();
      t_mid_reset();
      finish_test();
   end

   // The tests need well under a thousand cycles; this limit only cuts a hang.
   initial begin
      #100us;
      errorCnt++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
endmodule
